//--- rpku_pkg.sv
// Package of constants and types for the region and protection key unit.
package rpku_pkg;
   // -----------------------------------------------------------------
   // Sizes
   // -----------------------------------------------------------------
   localparam int unsigned NUM_REGIONS  = 8;
   localparam int unsigned NUM_KEYS     = 16;
   localparam int unsigned TAG_BITS     = 18;
   localparam int unsigned KEY_BITS     = 18;
   localparam int unsigned REG_W        = 64;
   localparam int unsigned RIDX_W       = 3;
   localparam int unsigned KIDX_W       = 4;
   localparam int unsigned PSIZE_W      = 6;
   // -----------------------------------------------------------------
   // Region attribute register fields
   // -----------------------------------------------------------------
   localparam int unsigned RA_WALK_BIT  = 0;
   localparam int unsigned RA_RSV_BIT   = 1;
   localparam int unsigned RA_PSIZE_LSB = 2;
   localparam int unsigned RA_TAG_LSB   = 8;
   localparam int unsigned RA_TAG_MSB   = 31;
   // -----------------------------------------------------------------
   // Domain key register fields
   // -----------------------------------------------------------------
   localparam int unsigned DK_VALID_BIT = 0;
   localparam int unsigned DK_WDENY_BIT = 1;
   localparam int unsigned DK_RDENY_BIT = 2;
   localparam int unsigned DK_XDENY_BIT = 3;
   localparam int unsigned DK_KEY_LSB   = 8;
   localparam int unsigned DK_KEY_MSB   = 31;
   // -----------------------------------------------------------------
   // Page sizes and reset values
   // -----------------------------------------------------------------
   localparam logic [5:0] PSIZE_4K     = 6'h0c;
   localparam logic [63:0] PSIZE_LEGAL = 64'h0000_0000_1555_7000;
   localparam logic [63:0] RA_RESET    = 64'h0000_0000_0000_0030;
   localparam logic [63:0] DK_RESET    = 64'h0000_0000_0000_0000;
   localparam int unsigned VA_REGION_LSB = 61;

   typedef enum logic [1:0] {
      RPKU_REF_DATA  = 2'h0,
      RPKU_REF_INSTR = 2'h1,
      RPKU_REF_STACK = 2'h2
   } rpku_ref_t;

   typedef struct packed {
      logic [TAG_BITS-1:0] tag;
      logic [PSIZE_W-1:0]  psize;
      logic                walk;
   } rpku_region_t;

   typedef struct packed {
      logic [KEY_BITS-1:0] key;
      logic                xdeny;
      logic                rdeny;
      logic                wdeny;
      logic                valid;
   } rpku_dkey_t;
endpackage

//--- rpku_key_if.sv
// Interface carrying the domain key array between the top and the key store.
interface rpku_key_if;
   logic                                  wr_en;
   logic [rpku_pkg::KIDX_W-1:0]           wr_idx;
   rpku_pkg::rpku_dkey_t                  wr_data;
   rpku_pkg::rpku_dkey_t [rpku_pkg::NUM_KEYS-1:0] keys;
   modport owner (output wr_en, output wr_idx, output wr_data, input keys);
   modport store (input wr_en, input wr_idx, input wr_data, output keys);
endinterface

//--- rpku_key_store.sv
// Domain key register array with uniqueness invalidation on valid writes.
module rpku_key_store (
   input  wire logic   clk,
   input  wire logic   resetn,
   rpku_key_if.store   kif
);
   typedef struct packed {
      rpku_pkg::rpku_dkey_t [rpku_pkg::NUM_KEYS-1:0] keys;
   } rpku_ks_state_t;

   rpku_ks_state_t st_r;
   rpku_ks_state_t st_nxt;

   always_comb begin
      st_nxt = st_r;
      if (kif.wr_en) begin
         if (kif.wr_data.valid) begin
            for (int i = 0; i < rpku_pkg::NUM_KEYS; i++) begin
               if (st_r.keys[i].valid && st_r.keys[i].key == kif.wr_data.key) begin
                  st_nxt.keys[i].valid = 1'b0;
               end
            end
         end
         st_nxt.keys[kif.wr_idx] = kif.wr_data;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign kif.keys = st_r.keys;
endmodule

//--- rpku_top.sv
// Region attribute and domain key registers with access key checking.
module rpku_top (
   input  wire logic        clk,
   input  wire logic        resetn,
   // Move instruction port.
   input  wire logic        mv_region_wr,
   input  wire logic        mv_key_wr,
   input  wire logic        mv_rd_region,
   input  wire logic        mv_rd_key,
   input  wire logic [3:0]  mv_idx,
   input  wire logic [63:0] mv_wdata,
   output logic [63:0]      mv_rdata,
   output logic             mv_rdata_valid,
   output logic             mv_rsvd_fault,
   // Processor status bits.
   input  wire logic        key_check_on,
   input  wire logic        data_xlate_on,
   input  wire logic        instr_xlate_on,
   input  wire logic        stack_xlate_on,
   // Translation insert and lookup.
   input  wire logic        xl_req,
   input  wire logic        xl_legacy,
   input  wire logic [63:0] xl_vaddr,
   output logic             xl_walk_en,
   output logic [5:0]       xl_psize,
   output logic [23:0]      xl_tag,
   output logic             xl_valid,
   // Access key check.
   input  wire logic        acc_req,
   input  wire logic [1:0]  acc_type,
   input  wire logic        acc_read,
   input  wire logic        acc_write,
   input  wire logic        acc_exec,
   input  wire logic [23:0] acc_key,
   output logic             acc_done,
   output logic             acc_key_miss,
   output logic             acc_key_perm,
   // Data translation entry key query.
   input  wire logic        dkq_req,
   input  wire logic [23:0] dkq_entry_key,
   output logic [23:0]      dkq_key,
   output logic             dkq_valid
);
   // -----------------------------------------------------------------
   // State
   // -----------------------------------------------------------------
   typedef struct packed {
      rpku_pkg::rpku_region_t [rpku_pkg::NUM_REGIONS-1:0] reg_a;
      logic [63:0] rdata;
      logic        rdata_valid;
      logic        rsvd_fault;
      logic        walk_en;
      logic [5:0]  psize;
      logic [23:0] tag;
      logic        xl_valid;
      logic        done;
      logic        miss;
      logic        perm;
      logic [23:0] dkey;
      logic        dvalid;
   } rpku_state_t;

   rpku_state_t st_r;
   rpku_state_t st_nxt;

   rpku_key_if kif ();

   rpku_key_store u_keys (
      .clk    (clk),
      .resetn (resetn),
      .kif    (kif)
   );

   // -----------------------------------------------------------------
   // Field helpers
   // -----------------------------------------------------------------
   function automatic logic [63:0] region_word(input rpku_pkg::rpku_region_t r);
      logic [63:0] w;
      w = '0;
      w[rpku_pkg::RA_WALK_BIT] = r.walk;
      w[rpku_pkg::RA_PSIZE_LSB +: rpku_pkg::PSIZE_W] = r.psize;
      w[rpku_pkg::RA_TAG_LSB +: rpku_pkg::TAG_BITS] = r.tag;
      return w;
   endfunction

   function automatic logic [23:0] widen_tag(input logic [rpku_pkg::TAG_BITS-1:0] t);
      logic [23:0] w;
      w = '0;
      w[rpku_pkg::TAG_BITS-1:0] = t;
      return w;
   endfunction

   // -----------------------------------------------------------------
   // Key matching
   // -----------------------------------------------------------------
   logic [rpku_pkg::NUM_KEYS-1:0] hit_vec;
   rpku_pkg::rpku_dkey_t          hit_key;

   genvar gi;
   generate
      for (gi = 0; gi < rpku_pkg::NUM_KEYS; gi++) begin : g_match
         assign hit_vec[gi] = kif.keys[gi].valid &&
            (kif.keys[gi].key == acc_key[rpku_pkg::KEY_BITS-1:0]) &&
            (acc_key[23:rpku_pkg::KEY_BITS] == '0);
      end
   endgenerate

   always_comb begin
      hit_key = '0;
      for (int i = 0; i < rpku_pkg::NUM_KEYS; i++) begin
         if (hit_vec[i]) begin
            hit_key = kif.keys[i];
         end
      end
   end

   // -----------------------------------------------------------------
   // Key write path
   // -----------------------------------------------------------------
   rpku_pkg::rpku_dkey_t key_wr;
   always_comb begin
      key_wr.valid = mv_wdata[rpku_pkg::DK_VALID_BIT];
      key_wr.wdeny = mv_wdata[rpku_pkg::DK_WDENY_BIT];
      key_wr.rdeny = mv_wdata[rpku_pkg::DK_RDENY_BIT];
      key_wr.xdeny = mv_wdata[rpku_pkg::DK_XDENY_BIT];
      key_wr.key   = mv_wdata[rpku_pkg::DK_KEY_LSB +: rpku_pkg::KEY_BITS];
   end

   assign kif.wr_en   = mv_key_wr;
   assign kif.wr_idx  = mv_idx;
   assign kif.wr_data = key_wr;

   // -----------------------------------------------------------------
   // Next state
   // -----------------------------------------------------------------
   logic                           xlate_on;
   logic [rpku_pkg::RIDX_W-1:0]    rsel;
   logic [5:0]                     wr_psize;
   rpku_pkg::rpku_dkey_t           rk;

   always_comb begin
      st_nxt = st_r;
      rk = kif.keys[mv_idx];
      wr_psize = mv_wdata[rpku_pkg::RA_PSIZE_LSB +: rpku_pkg::PSIZE_W];

      st_nxt.rsvd_fault = 1'b0;
      if (mv_region_wr) begin
         if (mv_idx[3] || !rpku_pkg::PSIZE_LEGAL[wr_psize] ||
             mv_wdata[rpku_pkg::RA_RSV_BIT] ||
             mv_wdata[63:rpku_pkg::RA_TAG_LSB + rpku_pkg::TAG_BITS] != '0) begin
            st_nxt.rsvd_fault = 1'b1;
         end else begin
            st_nxt.reg_a[mv_idx[2:0]].walk = mv_wdata[rpku_pkg::RA_WALK_BIT];
            st_nxt.reg_a[mv_idx[2:0]].psize = wr_psize;
            st_nxt.reg_a[mv_idx[2:0]].tag =
               mv_wdata[rpku_pkg::RA_TAG_LSB +: rpku_pkg::TAG_BITS];
         end
      end

      // Move-from reads.
      st_nxt.rdata_valid = mv_rd_region || mv_rd_key;
      st_nxt.rdata = '0;
      if (mv_rd_region && !mv_idx[3]) begin
         st_nxt.rdata = region_word(st_r.reg_a[mv_idx[2:0]]);
      end else if (mv_rd_key) begin
         st_nxt.rdata[rpku_pkg::DK_VALID_BIT] = rk.valid;
         st_nxt.rdata[rpku_pkg::DK_WDENY_BIT] = rk.wdeny;
         st_nxt.rdata[rpku_pkg::DK_RDENY_BIT] = rk.rdeny;
         st_nxt.rdata[rpku_pkg::DK_XDENY_BIT] = rk.xdeny;
         st_nxt.rdata[rpku_pkg::DK_KEY_LSB +: rpku_pkg::KEY_BITS] = rk.key;
      end

      rsel = xl_vaddr[rpku_pkg::VA_REGION_LSB +: rpku_pkg::RIDX_W];
      if (xl_legacy) begin
         rsel = '0;
      end
      st_nxt.xl_valid = xl_req;
      st_nxt.psize    = st_r.reg_a[rsel].psize;
      st_nxt.walk_en  = st_r.reg_a[rsel].walk;
      st_nxt.tag      = widen_tag(st_r.reg_a[rsel].tag);

      unique case (acc_type)
         rpku_pkg::RPKU_REF_DATA:  xlate_on = data_xlate_on;
         rpku_pkg::RPKU_REF_INSTR: xlate_on = instr_xlate_on;
         rpku_pkg::RPKU_REF_STACK: xlate_on = stack_xlate_on;
         default:                  xlate_on = 1'b0;
      endcase

      st_nxt.done = acc_req;
      st_nxt.miss = 1'b0;
      st_nxt.perm = 1'b0;
      if (acc_req && key_check_on && xlate_on) begin
         if (hit_vec == '0) begin
            st_nxt.miss = 1'b1;
         end else begin
            st_nxt.perm = (acc_write && hit_key.wdeny) ||
                          (acc_read  && hit_key.rdeny) ||
                          (acc_exec  && hit_key.xdeny);
         end
      end

      st_nxt.dvalid = dkq_req;
      st_nxt.dkey   = dkq_req ? dkq_entry_key : st_r.dkey;
   end

   // -----------------------------------------------------------------
   // Registers
   // -----------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st_r <= '0;
         for (int i = 0; i < rpku_pkg::NUM_REGIONS; i++) begin
            st_r.reg_a[i].psize <= rpku_pkg::PSIZE_4K;
         end
      end else begin
         st_r <= st_nxt;
      end
   end

   assign mv_rdata       = st_r.rdata;
   assign mv_rdata_valid = st_r.rdata_valid;
   assign mv_rsvd_fault  = st_r.rsvd_fault;
   assign xl_walk_en     = st_r.walk_en;
   assign xl_psize       = st_r.psize;
   assign xl_tag         = st_r.tag;
   assign xl_valid       = st_r.xl_valid;
   assign acc_done       = st_r.done;
   assign acc_key_miss   = st_r.miss;
   assign acc_key_perm   = st_r.perm;
   assign dkq_key        = st_r.dkey;
   assign dkq_valid      = st_r.dvalid;
endmodule

//--- rpku_checker.sv
// Concurrent checks on the ports of the region and protection key unit.
module rpku_checker (
   input wire logic        clk,
   input wire logic        resetn,
   input wire logic        mv_region_wr,
   input wire logic        mv_key_wr,
   input wire logic        mv_rd_region,
   input wire logic        mv_rd_key,
   input wire logic [3:0]  mv_idx,
   input wire logic        mv_rdata_valid,
   input wire logic        mv_rsvd_fault,
   input wire logic        key_check_on,
   input wire logic        data_xlate_on,
   input wire logic        xl_req,
   input wire logic        xl_valid,
   input wire logic [23:0] xl_tag,
   input wire logic        acc_req,
   input wire logic [1:0]  acc_type,
   input wire logic [23:0] acc_key,
   input wire logic        acc_done,
   input wire logic        acc_key_miss,
   input wire logic        acc_key_perm,
   input wire logic        dkq_req,
   input wire logic [23:0] dkq_entry_key,
   input wire logic [23:0] dkq_key,
   input wire logic        dkq_valid
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   sequence s_rd;
      mv_rd_region || mv_rd_key;
   endsequence
   sequence s_wide_data;
      acc_req && key_check_on && data_xlate_on && acc_type == 2'h0 && acc_key[23:18] != 6'h0;
   endsequence
   sequence s_fault;
      acc_done && (acc_key_miss || acc_key_perm);
   endsequence
   a_rd_answer: assert property (s_rd |=> mv_rdata_valid)
      else $error("read request without answer");
   a_rd_quiet: assert property (!(mv_rd_region || mv_rd_key) |=> !mv_rdata_valid)
      else $error("read answer without request");
   a_xl_answer: assert property (xl_req |=> xl_valid ##0 xl_tag[23:18] == 6'h0)
      else $error("lookup answer missing or wide tag");
   a_acc_answer: assert property (acc_req |=> acc_done)
      else $error("key check without answer");
   a_fault_idle: assert property (!acc_done |-> !acc_key_miss && !acc_key_perm)
      else $error("fault flag outside an answer");
   a_fault_gate: assert property (s_fault |-> $past(key_check_on) &&
      ($past(acc_type) != 2'h0 || $past(data_xlate_on)))
      else $error("fault while checking disabled");
   a_wide_miss: assert property (s_wide_data |=> acc_key_miss && !acc_key_perm)
      else $error("wide key did not miss");
   a_bad_region: assert property (mv_region_wr && mv_idx[3] |=> mv_rsvd_fault)
      else $error("region index out of range not refused");
   a_key_nofault: assert property (mv_key_wr && !mv_region_wr |=> !mv_rsvd_fault)
      else $error("key write raised a fault");
   a_key_echo: assert property (dkq_req |=> dkq_valid && dkq_key == $past(dkq_entry_key))
      else $error("entry key query wrong");
endmodule
bind rpku_top rpku_checker chk (.*);

//--- rpku_pipe_model.sv
// Pipeline and translation buffer model issuing lookups and key checks.
module rpku_pipe_model (
   input wire logic   clk,
   output logic        xl_req,
   output logic        xl_legacy,
   output logic [63:0] xl_vaddr,
   output logic        acc_req,
   output logic [1:0]  acc_type,
   output logic        acc_read,
   output logic        acc_write,
   output logic        acc_exec,
   output logic [23:0] acc_key,
   input wire logic    xl_valid,
   input wire logic    xl_walk_en,
   input wire logic [5:0]  xl_psize,
   input wire logic [23:0] xl_tag,
   input wire logic    acc_done,
   input wire logic    acc_key_miss,
   input wire logic    acc_key_perm
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      {xl_req, xl_legacy, xl_vaddr, acc_req, acc_type} = '0;
      {acc_read, acc_write, acc_exec, acc_key} = '0;
   end
   task automatic lookup(input logic lg, input logic [63:0] va, output logic [31:0] res);
      xl_legacy = lg;
      xl_vaddr = va;
      xl_req = 1'b1;
      @(posedge clk);
      #1;
      xl_req = 1'b0;
      xl_vaddr = ~va;
      res = {xl_valid, xl_walk_en, xl_psize, xl_tag};
      @(posedge clk);
      #1;
   endtask
   task automatic check(input logic [1:0] t, input logic [2:0] rwx, input logic [23:0] k,
                        output logic [2:0] res);
      acc_type = t;
      {acc_read, acc_write, acc_exec} = rwx;
      acc_key = k;
      acc_req = 1'b1;
      @(posedge clk);
      #1;
      acc_req = 1'b0;
      acc_key = ~k;
      res = {acc_done, acc_key_miss, acc_key_perm};
      @(posedge clk);
      #1;
   endtask
endmodule

//--- rpku_test.sv
// Self-checking bench for the region and protection key unit.
module rpku_test;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {
      logic [1:0] t; logic [2:0] rwx; logic [23:0] k; logic [3:0] st; logic [1:0] exp;
   } rpku_row_t;
   logic clk, resetn, mv_region_wr, mv_key_wr, mv_rd_region, mv_rd_key, mv_rdata_valid;
   logic mv_rsvd_fault, key_check_on, data_xlate_on, instr_xlate_on, stack_xlate_on;
   logic xl_req, xl_legacy, xl_walk_en, xl_valid, acc_req, acc_read, acc_write, acc_exec;
   logic acc_done, acc_key_miss, acc_key_perm, dkq_req, dkq_valid;
   logic [3:0] mv_idx;
   logic [63:0] mv_wdata, mv_rdata, xl_vaddr;
   logic [5:0] xl_psize;
   logic [1:0] acc_type;
   logic [23:0] xl_tag, acc_key, dkq_entry_key, dkq_key;
   logic [65:0] r;
   logic [31:0] x;
   logic [2:0] a;
   int errors, total_checks;
   logic [63:0] kv [4] = '{64'h12303, 64'h45605, 64'h78909, 64'haaa00};
   rpku_row_t rows [13] = '{
      '{2'h0, 3'h2, 24'h123, 4'hf, 2'h1}, '{2'h0, 3'h4, 24'h123, 4'hf, 2'h0},
      '{2'h0, 3'h4, 24'h456, 4'hf, 2'h1}, '{2'h1, 3'h1, 24'h789, 4'hf, 2'h1},
      '{2'h1, 3'h1, 24'h456, 4'hf, 2'h0}, '{2'h2, 3'h4, 24'h999, 4'hf, 2'h2},
      '{2'h0, 3'h4, 24'haaa, 4'hf, 2'h2}, '{2'h0, 3'h4, 24'h999, 4'h7, 2'h0},
      '{2'h0, 3'h4, 24'h999, 4'hb, 2'h0}, '{2'h1, 3'h1, 24'h789, 4'hd, 2'h0},
      '{2'h2, 3'h4, 24'h999, 4'he, 2'h0}, '{2'h0, 3'h4, 24'h40123, 4'hf, 2'h2},
      '{2'h3, 3'h4, 24'h999, 4'hf, 2'h0}};
   rpku_top uut (.*);
   rpku_pipe_model pm (.*);
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic chk(input logic [65:0] got, input logic [65:0] exp);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   // Each move completes before the next reference
   task automatic mv(input logic [3:0] op, input logic [3:0] idx, input logic [63:0] d);
      {mv_region_wr, mv_key_wr, mv_rd_region, mv_rd_key} = op;
      mv_idx = idx;
      mv_wdata = d;
      @(posedge clk);
      #1;
      {mv_region_wr, mv_key_wr, mv_rd_region, mv_rd_key} = 4'h0;
      mv_wdata = ~d;
      r = {mv_rsvd_fault, mv_rdata_valid, mv_rdata};
      @(posedge clk);
      #1;
   endtask
   task automatic tally_and_finish();
      if (errors == 0 && total_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      #4000;
      errors++;
      tally_and_finish();
   end
   initial begin
      {mv_region_wr, mv_key_wr, mv_rd_region, mv_rd_key, mv_idx, mv_wdata} = '0;
      {key_check_on, data_xlate_on, instr_xlate_on, stack_xlate_on} = 4'h0;
      {dkq_req, dkq_entry_key} = '0;
      resetn = 1'b0;
      repeat (3) @(posedge clk);
      #1 resetn = 1'b1;
      foreach (rows[i]) begin
         {key_check_on, data_xlate_on, instr_xlate_on, stack_xlate_on} = rows[i].st;
         if (i == 0) foreach (kv[j]) mv(4'h4, 4'(j + 2), kv[j]);
         pm.check(rows[i].t, rows[i].rwx, rows[i].k, a);
         chk(66'(a), {63'h0, 1'b1, rows[i].exp});
      end
      for (int i = 0; i < 8; i++) begin
         mv(4'h2, 4'(i), 64'h0);
         chk(r, {2'h1, rpku_pkg::RA_RESET});
      end
      mv(4'h1, 4'hf, 64'h0);
      chk(r, {2'h1, 64'h0});
      mv(4'h8, 4'h5, 64'h03ff_ff39);
      chk(66'(r[65]), 66'h0);
      pm.lookup(1'b0, 64'ha000_0000_0000_1000, x);
      chk(66'(x), 66'({2'h3, 6'h0e, 24'h03ffff}));
      pm.lookup(1'b1, 64'ha000_0000_0000_1000, x);
      chk(66'(x), 66'({2'h2, 6'h0c, 24'h0}));
      mv(4'h8, 4'h5, 64'h3d);
      chk(66'(r[65]), 66'h1);
      mv(4'h8, 4'h5, 64'h32);
      chk(66'(r[65]), 66'h1);
      mv(4'h8, 4'h8, 64'h30);
      chk(66'(r[65]), 66'h1);
      mv(4'h2, 4'h5, 64'h0);
      chk(r, {2'h1, 64'h03ff_ff39});
      mv(4'h4, 4'h8, 64'hffff_ffff_ffff_fff1);
      mv(4'h1, 4'h8, 64'h0);
      chk(r, {2'h1, 64'h03ff_ff01});
      mv(4'h4, 4'h7, 64'h12301);
      mv(4'h1, 4'h2, 64'h0);
      chk(r, {2'h1, 64'h12302});
      mv(4'h1, 4'h7, 64'h0);
      chk(r, {2'h1, 64'h12301});
      {key_check_on, data_xlate_on, instr_xlate_on, stack_xlate_on} = 4'hf;
      pm.check(2'h0, 3'h2, 24'h123, a);
      chk(66'(a), 66'h4);
      dkq_entry_key = 24'h0abcde;
      dkq_req = 1'b1;
      @(posedge clk);
      #1 dkq_req = 1'b0;
      chk(66'({dkq_valid, dkq_key}), 66'({1'b1, 24'h0abcde}));
      // A reset in mid-run returns every register to its reset value.
      @(posedge clk);
      #1 resetn = 1'b0;
      @(posedge clk);
      #1 resetn = 1'b1;
      mv(4'h2, 4'h5, 64'h0);
      chk(r, {2'h1, rpku_pkg::RA_RESET});
      mv(4'h1, 4'h7, 64'h0);
      chk(r, {2'h1, 64'h0});
      mv(4'h2, 4'h9, 64'h0);
      chk(r, {2'h1, 64'h0});
      tally_and_finish();
   end
endmodule
